//--- interrupt_vector_config.sv
/*
  Interrupt vector configuration: control and shadow select registers,
  vector offset and shadow set selection, proximity timer start, and
  external interrupt edge polarity.
  Assumes: a plain register port with read data one cycle after the strobe;
  the arbiter supplies the winning request number and group priority.
*/
// Behaviour
// - The spacing field gives 0 bytes when zero, else 8 shifted left by the set bit position.
// - In single-vectored operation the spacing field is ignored and the offset is zero.
// - Control bit 12 selects multivectored operation when one and single-vectored when zero.
// - A proximity field of 000 disables the proximity timer entirely.
// - A proximity field N of 2 to 7 lets interrupts of priority N or lower start the timer.
// - A proximity field of 001 lets only priority 1 interrupts start the timer.
// - Control bits 4 to 0 choose rising edge when one and falling edge when zero per input.
// - Each level's four-bit selector 0001 chooses shadow set 1 and 0000 chooses set 0.
// - Level selectors sit in nibbles from level 7 at bits 31-28 down to level 1 at bits 7-4.
// - Per-level selectors have no effect in single-vectored operation.
// - Shadow bit 0 presents the single vector with a shadow set when one, else none.
// - Unimplemented bits of both configuration registers read as zero.
// - All implemented bits are readable and writable and clear to zero at reset.
// - A timer trigger loads the count from the 32-bit software reload register.
`timescale 1ns/10ps
module interrupt_vector_config (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic [4:0] ext_irq_pin,
  output logic [4:0] ext_irq_edge,
  input wire logic irq_valid,
  input wire logic [7:0] irq_number,
  input wire logic [2:0] irq_priority,
  output logic vector_valid,
  output logic [15:0] vector_offset,
  output logic [3:0] vector_shadow_set,
  output logic vector_shadow_used,
  output logic timer_expired,
  output logic timer_running
);
  // ==========================================================================
  // configuration registers
  logic [31:0] interrupt_control;
  logic [31:0] priority_shadow_select;
  logic [31:0] proximity_reload;

  wire logic [6:0] vector_spacing = interrupt_control[intvec_pkg::VS_LSB +: intvec_pkg::VS_W];
  wire logic multi_vector_select = interrupt_control[intvec_pkg::MULTI_VECTOR_SELECT_BIT];
  wire logic [2:0] proximity_timer_threshold =
    interrupt_control[intvec_pkg::TPC_LSB +: intvec_pkg::TPC_W];
  wire logic [4:0] edge_sel = interrupt_control[intvec_pkg::EDGE_W-1:0];
  wire logic ext_irq_a_edge_sel = edge_sel[0];
  wire logic ext_irq_b_edge_sel = edge_sel[1];
  wire logic ext_irq_c_edge_sel = edge_sel[2];
  wire logic ext_irq_d_edge_sel = edge_sel[3];
  wire logic ext_irq_e_edge_sel = edge_sel[4];
  wire logic single_vector_shadow_enable = priority_shadow_select[intvec_pkg::SS0_BIT];

  // ==========================================================================
  // register decode
  wire logic hit_control = (reg_addr == intvec_pkg::IDX_CONTROL);
  wire logic hit_shadow = (reg_addr == intvec_pkg::IDX_SHADOW);
  wire logic hit_reload = (reg_addr == intvec_pkg::IDX_RELOAD);
  wire logic hit_timer = (reg_addr == intvec_pkg::IDX_TIMER);
  wire logic hit_shadow_out = (reg_addr == intvec_pkg::IDX_SHADOW_OUT);

  // writes mask off unimplemented bits so they can never read back as one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interrupt_control <= intvec_pkg::RESET_VALUE;
      priority_shadow_select <= intvec_pkg::RESET_VALUE;
      proximity_reload <= intvec_pkg::RESET_VALUE;
    end else if (reg_write) begin
      if (hit_control) begin
        interrupt_control <= reg_wdata & intvec_pkg::CONTROL_MASK;
      end
      if (hit_shadow) begin
        priority_shadow_select <= reg_wdata & intvec_pkg::SHADOW_MASK;
      end
      if (hit_reload) begin
        proximity_reload <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // read path
  logic [31:0] timer_count;
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000; // unmapped indices read as zero
    if (hit_control) next_rdata = interrupt_control;
    if (hit_shadow) next_rdata = priority_shadow_select;
    if (hit_reload) next_rdata = proximity_reload;
    if (hit_timer) next_rdata = timer_count;
    if (hit_shadow_out) next_rdata = {27'h0, vector_shadow_used, vector_shadow_set};
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) reg_rdata <= 32'h0000_0000;
    else reg_rdata <= reg_read ? next_rdata : 32'h0000_0000;
  end

  // ==========================================================================
  // helper functions
  // one-hot spacing to byte count; reserved patterns are left to software
  function automatic logic [9:0] spacing_bytes(input logic [6:0] vs);
    logic [9:0] acc;
    acc = 10'h000;
    for (int k = 0; k < intvec_pkg::VS_W; k++) begin
      if (vs[k]) acc = acc | 10'(intvec_pkg::SPACING_UNIT << (k + intvec_pkg::SPACING_BASE_SHIFT));
    end
    return acc;
  endfunction

  // nibble for level 1..7; level 7 is the top nibble
  function automatic logic [3:0] level_select(input logic [31:0] ss, input logic [2:0] lvl);
    logic [3:0] r;
    r = intvec_pkg::SHADOW_SET_NONE;
    for (int l = 1; l <= intvec_pkg::LEVELS; l++) begin
      if (lvl == 3'(l)) r = ss[l*intvec_pkg::SS_W +: intvec_pkg::SS_W];
    end
    return r;
  endfunction

  // ==========================================================================
  // vector presentation
  wire logic [9:0] spacing = spacing_bytes(vector_spacing);
  // offset is the low 16 bits of number times spacing; a single vector always sits at offset zero
  wire logic [17:0] full_offset = 18'(irq_number * spacing);
  wire logic [15:0] multi_offset = full_offset[15:0];
  wire logic [15:0] next_offset = multi_vector_select ? multi_offset : 16'h0000;
  wire logic [3:0] level_set = level_select(priority_shadow_select, irq_priority);
  // level selectors apply only in multivectored mode
  wire logic [3:0] next_set = multi_vector_select ? level_set : intvec_pkg::SHADOW_SET_NONE;
  wire logic next_used = multi_vector_select ? 1'b1 : single_vector_shadow_enable;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vector_valid <= 1'b0;
      vector_offset <= 16'h0000;
      vector_shadow_set <= intvec_pkg::SHADOW_SET_NONE;
      vector_shadow_used <= 1'b0;
    end else begin
      vector_valid <= irq_valid;
      if (irq_valid) begin
        vector_offset <= next_offset;
        vector_shadow_set <= next_set;
        vector_shadow_used <= next_used;
      end
    end
  end

  // ==========================================================================
  // proximity timer start
  wire logic timer_off = (proximity_timer_threshold == intvec_pkg::TPC_OFF);
  wire logic prio_ok = (proximity_timer_threshold == intvec_pkg::TPC_ONLY_ONE) ?
    (irq_priority == intvec_pkg::PRIO_ONE) :
    (irq_priority <= proximity_timer_threshold);
  wire logic timer_start = irq_valid & ~timer_off & prio_ok;

  proximity_timer u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .trigger(timer_start),
    .disable_timer(timer_off),
    .reload(proximity_reload),
    .count(timer_count),
    .running(timer_running),
    .expired(timer_expired)
  );

  // ==========================================================================
  // external interrupt inputs
  wire logic [4:0] polarity = {ext_irq_e_edge_sel, ext_irq_d_edge_sel, ext_irq_c_edge_sel,
    ext_irq_b_edge_sel, ext_irq_a_edge_sel};
  genvar g;
  generate
    for (g = 0; g < intvec_pkg::EDGE_W; g++) begin : g_ext
      ext_edge_detect u_edge (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin(ext_irq_pin[g]),
        .rising_sel(polarity[g]),
        .edge_pulse(ext_irq_edge[g])
      );
    end
  endgenerate
endmodule

//--- intvec_pkg.sv
/*
  Package for the interrupt vector configuration block: register indices,
  field positions, widths and reset values.
  Assumes: included before every other design file of the block.
*/
package intvec_pkg;
  // ==========================================================================
  // register map (word index; byte address is four times this)
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_SHADOW = 4'h1;
  localparam logic [3:0] IDX_RELOAD = 4'h2;
  localparam logic [3:0] IDX_TIMER = 4'h3;
  localparam logic [3:0] IDX_SHADOW_OUT = 4'h4;

  // ==========================================================================
  // field positions of interrupt_control
  localparam int VS_LSB = 16;
  localparam int VS_W = 7;
  localparam int MULTI_VECTOR_SELECT_BIT = 12;
  localparam int TPC_LSB = 8;
  localparam int TPC_W = 3;
  localparam int EDGE_W = 5;
  localparam logic [31:0] CONTROL_MASK = 32'h007F_171F;
  localparam logic [31:0] SHADOW_MASK = 32'hFFFF_FFF1;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // ==========================================================================
  // shadow selects and spacing
  localparam int SS_W = 4;
  localparam int LEVELS = 7;
  localparam int SS0_BIT = 0;
  localparam int SPACING_BASE_SHIFT = 3;
  localparam logic [9:0] SPACING_UNIT = 10'h001;
  localparam logic [3:0] SHADOW_SET_NONE = 4'h0;
  localparam logic [2:0] TPC_OFF = 3'h0;
  localparam logic [2:0] TPC_ONLY_ONE = 3'h1;
  localparam logic [2:0] PRIO_ONE = 3'h1;
endpackage

//--- ext_edge_detect.sv
/*
  One external interrupt input: two-stage synchroniser and edge detector
  with selectable polarity.
  Assumes: the pin is asynchronous to clk_sys; polarity comes from a register.
*/
`timescale 1ns/10ps
module ext_edge_detect (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin,
  input wire logic rising_sel,
  output logic edge_pulse
);
  // ==========================================================================
  // synchroniser
  logic sync_a;
  logic sync_b;
  logic last;
  // sync_a is read only by sync_b, to keep metastability contained
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  // ==========================================================================
  // edge decode; polarity is sampled each cycle so a change acts on later edges
  wire logic rise = sync_b & ~last;
  wire logic fall = ~sync_b & last;
  assign edge_pulse = rising_sel ? rise : fall;
endmodule

//--- proximity_timer.sv
/*
  Interrupt proximity timer: loads the reload value on a trigger and counts
  down to zero, flagging expiry for one cycle.
  Assumes: trigger is a one-cycle pulse from the configuration logic.
*/
`timescale 1ns/10ps
module proximity_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic trigger,
  input wire logic disable_timer,
  input wire logic [31:0] reload,
  output logic [31:0] count,
  output logic running,
  output logic expired
);
  // ==========================================================================
  // countdown
  wire logic at_one = (count == 32'h0000_0001);
  always_ff @(posedge clk_sys) begin
    if (reset || disable_timer) begin
      count <= 32'h0000_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (trigger) begin
      count <= reload;
      running <= (reload != 32'h0000_0000);
      expired <= 1'b0;
    end else if (running) begin
      count <= count - 32'h0000_0001;
      running <= ~at_one;
      expired <= at_one;
    end else begin
      expired <= 1'b0;
    end
  end
endmodule

//--- ivc_monitor.sv
/* Checker for interrupt_vector_config, bound to every instance.
   Assumes: one clock clk_sys and a synchronous active-high reset. */
`timescale 1ns/10ps
module ivc_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [4:0] ext_irq_pin,
  input wire logic [4:0] ext_irq_edge,
  input wire logic irq_valid,
  input wire logic [2:0] irq_priority,
  input wire logic vector_valid,
  input wire logic [15:0] vector_offset,
  input wire logic [3:0] vector_shadow_set,
  input wire logic vector_shadow_used,
  input wire logic timer_running
);
  // ==========================================================
  // copy of the control word, so mode checks need no probes
  logic [31:0] ctl;
  wire logic [2:0] tpc = ctl[10:8];
  wire logic lvl_one = irq_priority == 3'h1;
  wire logic start_ok = (tpc == 3'h1) ? lvl_one : (!lvl_one || tpc != 3'h0) &&
    irq_priority != 3'h0 && irq_priority <= tpc;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl <= 32'h0;
    end else if (reg_write && reg_addr == 4'h0) begin
      ctl <= reg_wdata & intvec_pkg::CONTROL_MASK;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // pin edge of the first input, seen at the pin before the synchroniser
  sequence s_rise0;
    !ext_irq_pin[0] ##1 ext_irq_pin[0];
  endsequence
  property p_vec; irq_valid |=> vector_valid; endproperty
  property p_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
  property p_mask; reg_read && reg_addr == 4'h0 |=> reg_rdata[31:23] == 9'h0; endproperty
  property p_single;
    irq_valid && !ctl[12] |=> vector_offset == 16'h0 && vector_shadow_set == 4'h0;
  endproperty
  property p_multi; irq_valid && ctl[12] |=> vector_shadow_used; endproperty
  property p_start; irq_valid && start_ok |=> ##[0:1] timer_running; endproperty
  property p_off; irq_valid && tpc == 3'h0 && !timer_running |=> !timer_running [*2]; endproperty
  property p_edge; s_rise0 ##0 ctl[0] |-> ##[1:4] ext_irq_edge[0]; endproperty
  property p_rst;
    disable iff (1'b0) reset |=> !vector_valid && reg_rdata == 32'h0;
  endproperty
  a_vec: assert property (p_vec) else $error("no vector after request");
  a_idle: assert property (p_idle) else $error("read data outside slot");
  a_mask: assert property (p_mask) else $error("unused control bits set");
  a_single: assert property (p_single) else $error("single mode offset");
  a_multi: assert property (p_multi) else $error("multi mode no shadow");
  a_start: assert property (p_start) else $error("timer not started");
  a_off: assert property (p_off) else $error("timer started while off");
  a_edge: assert property (p_edge) else $error("rising edge missed");
  a_rst: assert property (p_rst) else $error("outputs not clear");
endmodule
bind interrupt_vector_config ivc_monitor mon (.clk_sys(clk_sys), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .ext_irq_edge(ext_irq_edge),
  .irq_valid(irq_valid), .irq_priority(irq_priority), .vector_valid(vector_valid),
  .vector_offset(vector_offset), .vector_shadow_set(vector_shadow_set),
  .vector_shadow_used(vector_shadow_used), .timer_running(timer_running));

//--- cpu_vector_sink.sv
/* Model of the CPU core that takes presented vectors.
   Assumes: vector fields are valid in the cycle of vector_valid. */
`timescale 1ns/10ps
module cpu_vector_sink (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic vector_valid,
  input wire logic [15:0] vector_offset,
  input wire logic [3:0] vector_shadow_set,
  input wire logic vector_shadow_used,
  output logic [20:0] taken
);
  // ==========================================================
  // latch {used, set, offset}; the core only looks at valid cycles
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      taken <= 21'h0;
    end else if (vector_valid) begin
      taken <= {vector_shadow_used, vector_shadow_set, vector_offset};
    end
  end
endmodule

//--- interrupt_vector_config_bench.sv
/* Self-checking bench for interrupt_vector_config.
   Assumes: plain register port with read data one cycle after the strobe,
   and the vector sink model beside the design. */
`timescale 1ns/10ps
module interrupt_vector_config_bench;
  logic clk_sys, reset, reg_write, reg_read, irq_valid;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, sh, sp;
  logic [4:0] ext_irq_pin, ext_irq_edge, seen;
  logic [7:0] irq_number;
  logic [2:0] irq_priority;
  logic [15:0] vector_offset, rnd;
  logic [3:0] vector_shadow_set;
  logic vector_valid, vector_shadow_used, timer_expired, timer_running;
  logic [20:0] taken;
  int n_fail, cmp_count, cyc, e;
  interrupt_vector_config uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .ext_irq_edge(ext_irq_edge),
    .irq_valid(irq_valid), .irq_number(irq_number), .irq_priority(irq_priority),
    .vector_valid(vector_valid), .vector_offset(vector_offset),
    .vector_shadow_set(vector_shadow_set), .vector_shadow_used(vector_shadow_used),
    .timer_expired(timer_expired), .timer_running(timer_running));
  cpu_vector_sink sink (.clk_sys(clk_sys), .reset(reset), .vector_valid(vector_valid),
    .vector_offset(vector_offset), .vector_shadow_set(vector_shadow_set),
    .vector_shadow_used(vector_shadow_used), .taken(taken));
  // ==========================================================
  // helpers: stimulus source, expectations, bus cycles
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic go(input logic [2:0] t, input logic [2:0] p);
    if (t == 3'h1) begin
      return p == 3'h1;
    end
    return p != 3'h0 && p <= t;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic irq(input logic [7:0] n, input logic [2:0] p);
    @(posedge clk_sys);
    irq_valid <= 1'b1;
    irq_number <= n;
    irq_priority <= p;
    @(posedge clk_sys);
    irq_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // drive all pins, gather edge pulses for a few cycles
  task automatic pins(input logic [4:0] v, input logic [4:0] exp);
    @(posedge clk_sys);
    ext_irq_pin <= v;
    seen = 5'h0;
    repeat (7) begin
      @(posedge clk_sys);
      #1 seen = seen | ext_irq_edge;
    end
    chk({27'h0, seen}, {27'h0, exp});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {reg_write, reg_read, irq_valid, reg_addr, reg_wdata} = '0;
    {ext_irq_pin, irq_number, irq_priority, n_fail, cmp_count, cyc} = '0;
    reset = 1'b1;
    rnd = 16'hD240;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, d);
    chk(d, 32'h0);
    rd(4'h1, d);
    chk(d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      sh = {rnd, lfsr(rnd)};
      wr(4'h0, sh & 32'hFF80_FFFF);
      rd(4'h0, d);
      chk(d, sh & 32'h0000_171F);
      wr(4'h1, sh & 32'h1111_111F);
      rd(4'h1, d);
      chk(d, sh & 32'h1111_1111);
    end
    rd(4'hF, d);
    chk(d, 32'h0);
    wr(4'h2, 32'h0000_0040);
    for (int k = 0; k < 8; k++) begin
      sp = (k == 7) ? 32'h0 : 32'h8 << k;
      wr(4'h0, 32'h0000_1000 | ((sp >> 3) << 16));
      rnd = lfsr(rnd);
      irq(rnd[7:0], 3'h0);
      chk({16'h0, taken[15:0]}, (rnd[7:0] * sp) & 32'hFFFF);
    end
    sh = {rnd, lfsr(rnd)} & 32'h1111_1111;
    wr(4'h1, sh);
    for (int p = 1; p < 8; p++) begin
      irq(rnd[7:0], p[2:0]);
      chk({27'h0, taken[20:16]}, {28'h1, sh[4 * p +: 4]});
    end
    wr(4'h0, 32'h0040_0000);
    repeat (2) begin
      sh = sh ^ 32'h1;
      wr(4'h1, sh);
      irq(8'hFF, 3'h7);
      chk({11'h0, taken}, {11'h0, sh[0], 20'h0});
      // the shadow output register mirrors what was last presented
      rd(4'h4, d);
      chk(d, {27'h0, sh[0], 4'h0});
    end
    for (int t = 0; t < 8; t++) begin
      for (int p = 1; p < 8; p++) begin
        wr(4'h0, 32'h0);
        wr(4'h0, t << 8);
        irq(8'h01, p[2:0]);
        chk({31'h0, timer_running}, {31'h0, go(t[2:0], p[2:0])});
      end
    end
    // short reload: read back, count seen in flight, one expiry pulse, then idle
    wr(4'h2, 32'h0000_0010);
    rd(4'h2, d);
    chk(d, 32'h0000_0010);
    irq(8'h02, 3'h1);
    // loaded at the request edge, then two decrements before the read edge
    rd(4'h3, d);
    chk(d, 32'h0000_000E);
    e = 0;
    repeat (30) begin
      @(posedge clk_sys);
      #1 e += timer_expired;
    end
    chk(e, 1);
    chk({31'h0, timer_running}, 32'h0);
    // a reset in mid-run must clear both configuration registers again
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, d);
    chk(d, 32'h0);
    rd(4'h1, d);
    chk(d, 32'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(4'h0, {27'h0, rnd[4:0]});
      pins(5'h1F, rnd[4:0]);
      pins(5'h00, ~rnd[4:0]);
    end
    summarize();
  end
endmodule
